// ### pdb_bist_policy.sv
// Purpose: Policy engine and protocol sequencing for the carrier-mode self test.
// Assumes: Receive and transmit indications are synchronous one-cycle pulses.
// Notes:   The physical layer owns CRC arithmetic; this block requests it.
// Operation
// [RULE1] Accept message only if identifier differs.
// [RULE2] Build acknowledgement after accepting the message.
// [RULE3] Physical layer appends CRC to acknowledgement.
// [RULE4] Tester recomputes and checks acknowledgement CRC.
// [RULE5] Tester strips CRC, forwards acknowledgement upward.
// [RULE6] Tester bumps counter and stops its timer.
// [RULE7] Tester policy learns message was delivered.
// [RULE8] After acknowledgement, enter carrier mode, tell protocol.
// [RULE9] Protocol layer tells physical layer to enter.
// [RULE10] In carrier mode, policy requests the pattern.
// [RULE11] Protocol layer passes pattern request to physical.
// [RULE12] Pattern is sent continuously, unframed, without gaps.
// [RULE13] Tester accepts the continuous pattern stream.
// [RULE14] Leave carrier mode when the interval elapses.
// [RULE15] States run entry and exit actions.
// [RULE16] State timers start on entry, stop on exit.
// [RULE17] Only the no-response timer persists across states.
// [RULE18] Timer expiry is a state transition condition.
// [RULE19] Priority: protocol, then internal, then manager.
// [RULE20] Some transitions apply from any state.
// [RULE21] Discarded message retried after incoming handled.
// [RULE22] Ignore traffic in carrier mode, then restore.
`timescale 1ns/100ps
`include "pdb_defines.svh"
module pdb_bist_policy #(
	parameter int unsigned CONT_CYC   = `PDB_CONT_MODE_US * `PDB_CLK_MHZ,
	parameter int unsigned NORESP_CYC = `PDB_NORESP_US * `PDB_CLK_MHZ
) (
	// Clock and reset.
	input  wire logic                     CLK,
	input  wire logic                     RST_N,
	// Received message from the physical layer, CRC already checked.
	input  wire logic                     RX_VALID,
	input  wire logic                     RX_IS_BIST,
	input  wire logic                     RX_CARRIER,
	input  wire logic [`PDB_MSG_ID_W-1:0] RX_MSG_ID,
	// Transmit path handshake.
	input  wire logic                     TX_SENT,
	input  wire logic                     TX_DISCARDED,
	output logic                          TX_GOODCRC,
	output logic                          TX_APPEND_CRC,
	output logic [`PDB_MSG_ID_W-1:0]      TX_GOODCRC_ID,
	// Device policy manager and global events.
	input  wire logic                     DPM_REQ,
	input  wire logic                     HARD_RESET,
	output logic                          DPM_ACK,
	output logic                          MSG_TO_PE,
	output logic                          RETRY_REQ,
	output logic                          NORESP_TIMEOUT,
	// Carrier mode controls and pattern stream.
	output logic                          PRL_CARRIER_MODE,
	output logic                          PHY_CARRIER_MODE,
	output logic                          PRL_PATTERN_EN,
	output logic                          PHY_PATTERN_VALID,
	output logic                          PHY_PATTERN_BIT
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.

	pdb_pkg::pdb_state_t state_q;            // Present policy state.
	pdb_pkg::pdb_state_t state_d;            // Next policy state.
	logic [`PDB_MSG_ID_W-1:0] id_q;          // Stored identifier.
	logic                     id_vld_q;      // Identifier has been stored.
	logic [31:0]              cont_q;        // Carrier-mode timer.
	logic [31:0]              noresp_q;      // Persistent no-response timer.
	logic                     noresp_run_q;  // No-response timer running.
	logic                     pend_q;        // Discarded message awaits retry.
	logic                     in_idle;       // Decoded idle state.
	logic                     in_car;        // Decoded carrier state.
	logic                     id_new;        // Incoming identifier differs.
	logic                     accept;        // Message accepted.
	logic                     bist_acc;      // Accepted carrier-mode request.
	logic                     cont_exp;      // Carrier interval elapsed.
	logic                     noresp_exp;    // No-response interval elapsed.
	logic                     dpm_take;      // Manager request served.

	pdb_pat_if pat ();

	////////////////////////////////////////////////////////////////////////////////
	// Decode.

	assign in_idle    = (state_q == pdb_pkg::S_IDLE);
	assign in_car     = (state_q == pdb_pkg::S_CARRIER);
	assign id_new     = !id_vld_q || (RX_MSG_ID != id_q); // [RULE1]
	// Traffic is only taken in idle, so carrier mode ignores it. [RULE22]
	assign accept     = RX_VALID && in_idle && id_new;
	assign bist_acc   = accept && RX_IS_BIST && RX_CARRIER;
	assign cont_exp   = in_car && (cont_q == CONT_CYC - 1); // [RULE18]
	assign noresp_exp = noresp_run_q && (noresp_q == NORESP_CYC - 1);
	// Manager requests lose to receive indications and timer events. [RULE19]
	assign dpm_take   = DPM_REQ && in_idle && !RX_VALID && !noresp_exp;
	assign pat.en     = PRL_PATTERN_EN;

	// Next-state selection; hard reset wins from any state.
	always_comb begin
		state_d = state_q;
		if (HARD_RESET) begin
			state_d = pdb_pkg::S_IDLE; // [RULE20]
		end else begin
			case (state_q)
				pdb_pkg::S_IDLE:    state_d = bist_acc ? pdb_pkg::S_ACK : state_q;
				pdb_pkg::S_ACK:     state_d = TX_SENT ? pdb_pkg::S_ENTER : state_q; // [RULE8]
				pdb_pkg::S_ENTER:   state_d = pdb_pkg::S_CARRIER;
				pdb_pkg::S_CARRIER: state_d = cont_exp ? pdb_pkg::S_EXIT : state_q; // [RULE14]
				pdb_pkg::S_EXIT:    state_d = pdb_pkg::S_IDLE;
				default:            state_d = pdb_pkg::S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State, identifier and acknowledgement.

	// State register and identifier store.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q  <= pdb_pkg::S_IDLE;
			id_q     <= `PDB_MSG_ID_RST;
			id_vld_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (HARD_RESET) begin
				id_vld_q <= 1'b0; // Protocol reset forgets the identifier.
			end else if (accept) begin
				id_q     <= RX_MSG_ID; // [RULE1]
				id_vld_q <= 1'b1;
			end
		end
	end

	// Each accepted message is handed up and acknowledged with CRC appended, unless hard reset comes in the same cycle.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			MSG_TO_PE     <= 1'b0;
			TX_GOODCRC    <= 1'b0;
			TX_APPEND_CRC <= 1'b0;
			TX_GOODCRC_ID <= `PDB_MSG_ID_RST;
			DPM_ACK       <= 1'b0;
		end else begin
			MSG_TO_PE     <= accept && !HARD_RESET;
			TX_GOODCRC    <= accept && !HARD_RESET; // [RULE2]
			TX_APPEND_CRC <= accept && !HARD_RESET; // [RULE3]
			DPM_ACK       <= dpm_take && !HARD_RESET;
			if (accept) begin
				TX_GOODCRC_ID <= RX_MSG_ID;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode controls: entry and exit actions of each state.

	// Protocol flags are set by the policy; physical flags follow a cycle later, except that hard reset clears both carrier-mode flags at once.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			PRL_CARRIER_MODE <= 1'b0;
			PHY_CARRIER_MODE <= 1'b0;
			PRL_PATTERN_EN   <= 1'b0;
		end else if (HARD_RESET) begin
			PRL_CARRIER_MODE <= 1'b0;
			PHY_CARRIER_MODE <= 1'b0;
			PRL_PATTERN_EN   <= 1'b0;
		end else begin
			// Entry to ENTER commands protocol carrier mode. [RULE15] [RULE8]
			if (state_d == pdb_pkg::S_ENTER && !PRL_CARRIER_MODE) begin
				PRL_CARRIER_MODE <= 1'b1;
			end else if (state_d == pdb_pkg::S_EXIT) begin
				PRL_CARRIER_MODE <= 1'b0; // Exit action restores normal mode. [RULE22]
			end
			PHY_CARRIER_MODE <= PRL_CARRIER_MODE; // [RULE9]
			// Pattern is requested for as long as the next state is the carrier state. [RULE10]
			PRL_PATTERN_EN   <= (state_d == pdb_pkg::S_CARRIER);
		end
	end

	// Pattern stream is re-registered so the pins come from flip-flops.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			PHY_PATTERN_VALID <= 1'b0;
			PHY_PATTERN_BIT   <= 1'b0;
		end else begin
			PHY_PATTERN_VALID <= PRL_PATTERN_EN; // [RULE11]
			PHY_PATTERN_BIT   <= pat.bit_val;    // [RULE12]
		end
	end

	pdb_pattern_gen #(
		.BIT_DIV (`PDB_BIT_DIV)
	) u_gen (
		.CLK   (CLK),
		.RST_N (RST_N),
		.pat   (pat.gen)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Timers.

	// The carrier timer lives only in the carrier state and clears on leaving.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cont_q <= 32'h0000_0000;
		end else if (in_car && !cont_exp && !HARD_RESET) begin
			cont_q <= cont_q + 32'h0000_0001; // [RULE16]
		end else begin
			cont_q <= 32'h0000_0000;
		end
	end

	// The no-response timer persists across states until a new message or
	// hard reset; the level it raises is sticky so software-free logic sees it.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			noresp_q       <= 32'h0000_0000;
			noresp_run_q   <= 1'b0;
			NORESP_TIMEOUT <= 1'b0;
		end else if (HARD_RESET || accept) begin
			noresp_q       <= 32'h0000_0000;
			noresp_run_q   <= bist_acc && !HARD_RESET;
			// An expiry in the same cycle as an accept still raises the flag.
			NORESP_TIMEOUT <= noresp_exp && !HARD_RESET; // [RULE18]
		end else if (noresp_exp) begin
			noresp_run_q   <= 1'b0; // [RULE17]
			NORESP_TIMEOUT <= 1'b1; // [RULE18]
		end else if (noresp_run_q) begin
			noresp_q <= noresp_q + 32'h0000_0001; // [RULE17]
		end
	end

	// A discarded send is retried once idle with no incoming message pending;
	// a new discard in the retry cycle wins over the clear.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pend_q    <= 1'b0;
			RETRY_REQ <= 1'b0;
		end else begin
			RETRY_REQ <= pend_q && in_idle && !RX_VALID && !HARD_RESET; // [RULE21]
			if (TX_DISCARDED) begin
				pend_q <= 1'b1;
			end else if (HARD_RESET || (pend_q && in_idle && !RX_VALID)) begin
				pend_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	sequence s_ack_done;
		state_q == pdb_pkg::S_ACK && TX_SENT && !HARD_RESET;
	endsequence

	sequence s_mode_up;
		PRL_CARRIER_MODE ##1 PHY_CARRIER_MODE && PRL_PATTERN_EN ##1 PHY_PATTERN_VALID;
	endsequence

	chk_dup_id_drop: assert property ( // [RULE1]
		RX_VALID && in_idle && id_vld_q && RX_MSG_ID == id_q |=> !MSG_TO_PE)
		else $error("Duplicate identifier was accepted.");

	chk_ack_with_crc: assert property ( // [RULE2]
		MSG_TO_PE |-> TX_GOODCRC && TX_APPEND_CRC && TX_GOODCRC_ID == id_q)
		else $error("Acknowledgement missing or malformed.");

	chk_entry_chain: assert property ( // [RULE8]
		s_ack_done |=> s_mode_up)
		else $error("Carrier entry sequence broken.");

	chk_phy_follow: assert property ( // [RULE9]
		$changed(PRL_CARRIER_MODE) |=> PHY_CARRIER_MODE == $past(PRL_CARRIER_MODE))
		else $error("Physical mode did not follow protocol mode.");

	chk_pattern_gapless: assert property ( // [RULE12]
		in_car && $past(in_car) |-> PHY_PATTERN_VALID)
		else $error("Pattern stream had a gap.");

	chk_mode_expiry: assert property ( // [RULE14]
		cont_exp && !HARD_RESET |=> state_q == pdb_pkg::S_EXIT ##1 !PHY_CARRIER_MODE)
		else $error("Carrier mode did not end on expiry.");

	chk_timer_scope: assert property ( // [RULE16]
		!in_car |=> cont_q == 32'h0000_0000)
		else $error("Carrier timer ran outside its state.");

	chk_dpm_last: assert property ( // [RULE19]
		DPM_REQ && RX_VALID |=> !DPM_ACK)
		else $error("Manager request beat a receive indication.");

	chk_any_reset: assert property ( // [RULE20]
		HARD_RESET |=> in_idle && !PRL_CARRIER_MODE && !PRL_PATTERN_EN)
		else $error("Hard reset did not return to idle.");

	chk_rx_ignored: assert property ( // [RULE22]
		RX_VALID && !in_idle |=> !MSG_TO_PE)
		else $error("Traffic accepted outside idle.");

endmodule

// ### pdb_defines.svh
// Purpose: Constants for the carrier-mode self-test policy block.
// Assumes: A 125 MHz core clock.
// Notes:   Times are kept in microseconds; cycle counts derive from them.
`ifndef PDB_DEFINES_SVH
`define PDB_DEFINES_SVH

// Core clock rate in MHz.
`define PDB_CLK_MHZ        125
// Carrier-mode duration in microseconds (plain default, tune per product).
`define PDB_CONT_MODE_US   50000
// Persistent no-response interval in microseconds (plain default).
`define PDB_NORESP_US      100000
// Core cycles per pattern bit.
`define PDB_BIT_DIV        4
// Width of the message identifier.
`define PDB_MSG_ID_W       3
// Reset value of the stored identifier.
`define PDB_MSG_ID_RST     3'h0

`endif

// ### pdb_pkg.sv
// Purpose: Types shared by the carrier-mode self-test policy block.
// Assumes: Nothing beyond the defines header.
// Notes:   States are one-hot, but each state's actions decode from a compare of the whole state.
package pdb_pkg;

	// Policy states, one-hot.
	typedef enum logic [4:0] {
		S_IDLE    = 5'h01,
		S_ACK     = 5'h02,
		S_ENTER   = 5'h04,
		S_CARRIER = 5'h08,
		S_EXIT    = 5'h10
	} pdb_state_t;

endpackage

// ### pdb_pat_if.sv
// Purpose: Link between the policy engine and the pattern generator.
// Assumes: Single clock domain.
// Notes:   The generator runs only while enable is high.
`timescale 1ns/100ps
interface pdb_pat_if;
	logic en;      // Generator enable.
	logic bit_val; // Present pattern bit.
	logic tick;    // One-cycle pulse at each new bit.

	modport gen (input en, output bit_val, output tick);
	modport ctl (output en, input bit_val, input tick);
endinterface

// ### pdb_pattern_gen.sv
// Purpose: Continuous alternating carrier pattern generator.
// Assumes: Enable is held for the whole carrier interval.
// Notes:   The bit rate is a one-cycle enable from a divider.
`timescale 1ns/100ps
`include "pdb_defines.svh"
module pdb_pattern_gen #(
	parameter int unsigned BIT_DIV = `PDB_BIT_DIV
) (
	// Clock and reset.
	input  wire logic CLK,
	input  wire logic RST_N,
	// Link to the policy engine.
	pdb_pat_if.gen    pat
);

	logic [15:0] div_q;   // Bit-rate divider.
	logic        wrap;    // Divider end of count.
	logic        bit_q;   // Pattern bit.
	logic        tick_q;  // Bit strobe.

	assign wrap        = (div_q == 16'(BIT_DIV - 1));
	assign pat.bit_val = bit_q;
	assign pat.tick    = tick_q;

	// Divider restarts while idle so the first bit has full length.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			div_q  <= 16'h0000;
			bit_q  <= 1'b0;
			tick_q <= 1'b0;
		end else if (!pat.en) begin
			div_q  <= 16'h0000;
			bit_q  <= 1'b0;
			tick_q <= 1'b0;
		end else begin
			div_q  <= wrap ? 16'h0000 : div_q + 16'h0001;
			tick_q <= wrap;
			if (wrap) begin
				bit_q <= ~bit_q; // Toggle with no gaps. [RULE12]
			end
		end
	end

	// The bit must alternate on each strobe while enabled.
	chk_bit_alternates: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE12]
		pat.en && tick_q && $past(pat.en) |-> bit_q != $past(bit_q, BIT_DIV))
		else $error("Pattern bit did not alternate.");

endmodule

// ### pdb_tester_model.sv
// Purpose: Tester-side partner that acknowledges and measures the unit.
// Assumes: The unit's outputs are registered, so they are sampled on the falling edge.
// Notes:   The sent indication comes after a chosen delay, so pacing can vary.
`timescale 1ns/100ps
`include "pdb_defines.svh"
module pdb_tester_model (
	// Clock and reset.
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	// Acknowledgement path from the unit.
	input  wire logic                     goodcrc,
	input  wire logic                     append_crc,
	input  wire logic [`PDB_MSG_ID_W-1:0] goodcrc_id,
	input  wire logic [3:0]               ack_delay,
	output logic                          sent,
	// Pattern stream from the unit.
	input  wire logic                     pat_valid,
	input  wire logic                     pat_bit,
	// Tester bookkeeping.
	output logic [`PDB_MSG_ID_W-1:0]      msg_id_cnt,
	output int                            n_ok,
	output int                            n_bad,
	output int                            n_valid,
	output int                            n_flips
);
	////////////////////////////////////////////////////////////////////////////
	logic prev_valid; // Previous sample lay inside the stream.
	logic prev_bit;   // Previous pattern bit.

	// Start with nothing counted and the sent line low.
	initial begin
		{sent, prev_valid, prev_bit} = 3'h0;
		msg_id_cnt = 3'h0;
		{n_ok, n_bad, n_valid, n_flips} = {4{32'h0}};
	end

	// An acknowledgement without a CRC cannot be validated, so it is counted as bad.
	always begin
		@(negedge clk);
		if (rst_n === 1'b1 && goodcrc === 1'b1) begin
			if (append_crc !== 1'b1) begin
				n_bad++;
			end else begin
				msg_id_cnt = goodcrc_id + 3'h1;
				n_ok++;
			end
			repeat (ack_delay) @(negedge clk);
			@(negedge clk);
			sent = 1'b1;
			@(negedge clk);
			sent = 1'b0;
		end
	end

	// A gap in the stream restarts the run, so flips only count inside one run.
	always @(negedge clk) begin
		if (pat_valid === 1'b1) begin
			n_valid++;
			if (prev_valid && pat_bit !== prev_bit) n_flips++;
		end
		prev_valid = (pat_valid === 1'b1);
		prev_bit = pat_bit;
	end
endmodule

// ### tb_top.sv
// Purpose: Self-checking bench for the carrier-mode self-test policy block.
// Assumes: Short carrier and no-response intervals keep the run brief.
// Notes:   Accepted messages are queued by the driver and matched by a monitor.
`timescale 1ns/100ps
`include "pdb_defines.svh"
module tb_top;
	localparam int unsigned CONT = 20;   // Carrier interval in cycles.
	localparam int unsigned NORESP = 50; // No-response interval in cycles.
	////////////////////////////////////////////////////////////////////////////
	logic CLK = 1'b0;
	logic RST_N, RX_VALID, RX_IS_BIST, RX_CARRIER, TX_SENT, TX_DISCARDED, DPM_REQ, HARD_RESET;
	logic [2:0] RX_MSG_ID, TX_GOODCRC_ID, last, id_cnt;
	logic TX_GOODCRC, TX_APPEND_CRC, DPM_ACK, MSG_TO_PE, RETRY_REQ, NORESP_TIMEOUT;
	logic PRL_CARRIER_MODE, PHY_CARRIER_MODE, PRL_PATTERN_EN, PHY_PATTERN_VALID, PHY_PATTERN_BIT;
	logic [3:0] ack_dly;              // Partner's acknowledge pacing.
	logic [31:0] seed = 32'h22D35D3D; // Random state.
	logic have;                       // The unit holds a stored identifier.
	logic [2:0] exp_q[$];             // Identifiers expected on accepts.
	int n_fail = 0, checked = 0, cyc = 0, t_acc, k, i, f0, v0, n_ok, n_bad, n_valid, n_flips;

	always #4 CLK = ~CLK;
	always @(posedge CLK) cyc <= cyc + 1;

	pdb_bist_policy #(.CONT_CYC(CONT), .NORESP_CYC(NORESP)) u_dut (.CLK(CLK), .RST_N(RST_N),
		.RX_VALID(RX_VALID), .RX_IS_BIST(RX_IS_BIST), .RX_CARRIER(RX_CARRIER),
		.RX_MSG_ID(RX_MSG_ID), .TX_SENT(TX_SENT), .TX_DISCARDED(TX_DISCARDED),
		.TX_GOODCRC(TX_GOODCRC), .TX_APPEND_CRC(TX_APPEND_CRC), .TX_GOODCRC_ID(TX_GOODCRC_ID),
		.DPM_REQ(DPM_REQ), .HARD_RESET(HARD_RESET), .DPM_ACK(DPM_ACK), .MSG_TO_PE(MSG_TO_PE),
		.RETRY_REQ(RETRY_REQ), .NORESP_TIMEOUT(NORESP_TIMEOUT),
		.PRL_CARRIER_MODE(PRL_CARRIER_MODE), .PHY_CARRIER_MODE(PHY_CARRIER_MODE),
		.PRL_PATTERN_EN(PRL_PATTERN_EN), .PHY_PATTERN_VALID(PHY_PATTERN_VALID),
		.PHY_PATTERN_BIT(PHY_PATTERN_BIT));
	pdb_tester_model u_tester (.clk(CLK), .rst_n(RST_N), .goodcrc(TX_GOODCRC),
		.append_crc(TX_APPEND_CRC), .goodcrc_id(TX_GOODCRC_ID), .ack_delay(ack_dly),
		.sent(TX_SENT), .pat_valid(PHY_PATTERN_VALID), .pat_bit(PHY_PATTERN_BIT),
		.msg_id_cnt(id_cnt), .n_ok(n_ok), .n_bad(n_bad), .n_valid(n_valid), .n_flips(n_flips));

	////////////////////////////////////////////////////////////////////////////
	// Compare one value and count the outcome.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// Print the counts and the verdict, then stop.
	task automatic print_verdict();
		$display("TB: checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Xorshift step for random identifiers.
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// Present one message for one cycle; the expected accept is noted first.
	task automatic send(input logic [2:0] id, input logic bist, input logic dpm, input logic dsc);
		if (!have || id != last) begin
			exp_q.push_back(id);
			last = id;
			have = 1'b1;
		end
		@(negedge CLK);
		{RX_VALID, RX_IS_BIST, RX_CARRIER, DPM_REQ, TX_DISCARDED} = {1'b1, bist, bist, dpm, dsc};
		RX_MSG_ID = id;
		@(negedge CLK);
		{RX_VALID, TX_DISCARDED} = 2'b00;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Every accept must match the oldest note; an accept with no note is an error.
	always @(negedge CLK) begin
		if (RST_N === 1'b1 && MSG_TO_PE !== 1'b0) begin
			t_acc = cyc;
			if (exp_q.size() == 0) begin
				check(MSG_TO_PE, 1'b0);
			end else begin
				check(TX_GOODCRC_ID, exp_q.pop_front());
				check({TX_GOODCRC, TX_APPEND_CRC}, 2'b11);
			end
		end
	end

	// Cut a hang short well beyond the few hundred cycles the tests need.
	initial begin
		repeat (4000) @(posedge CLK);
		n_fail++;
		$display("[FAIL] %0t watchdog expired", $time);
		print_verdict();
	end

	////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		{RX_VALID, RX_IS_BIST, RX_CARRIER, TX_DISCARDED, DPM_REQ, HARD_RESET, RST_N, have} = 8'h00;
		{RX_MSG_ID, ack_dly} = 7'h03;
		repeat (2) @(negedge CLK);
		RST_N = 1'b1;
		check({TX_GOODCRC, MSG_TO_PE, DPM_ACK, RETRY_REQ, NORESP_TIMEOUT, PRL_CARRIER_MODE}, 6'h00);
		// Carrier run with a slow acknowledge; a message mid-run must be ignored.
		{f0, v0} = {n_flips, n_valid};
		send(3'h5, 1'b1, 1'b0, 1'b0);
		for (k = 0; k < 40 && PRL_CARRIER_MODE !== 1'b1; k++) @(negedge CLK);
		check({PRL_CARRIER_MODE, PHY_CARRIER_MODE, PRL_PATTERN_EN}, 3'h4);
		@(negedge CLK);
		check({PHY_CARRIER_MODE, PRL_PATTERN_EN, PHY_PATTERN_VALID}, 3'h6);
		@(negedge CLK);
		check(PHY_PATTERN_VALID, 1'b1);
		for (k = 2; PRL_PATTERN_EN === 1'b1 && k < 100; k++) begin
			RX_VALID = (k == 6);
			RX_MSG_ID = 3'h6;
			@(negedge CLK);
		end
		RX_VALID = 1'b0;
		check(k - 1, CONT);
		check({PRL_CARRIER_MODE, PHY_CARRIER_MODE, PHY_PATTERN_VALID}, 3'h3);
		@(negedge CLK);
		check({PHY_CARRIER_MODE, PHY_PATTERN_VALID}, 2'h0);
		check(n_valid - v0, CONT);
		check((n_flips - f0) inside {[CONT / 4 - 1 : CONT / 4]}, 1'b1);
		check({id_cnt, n_bad[1:0]}, 5'h18);
		// The no-response timer keeps counting after the carrier states.
		for (k = 0; k < 80 && NORESP_TIMEOUT !== 1'b1; k++) @(negedge CLK);
		check((cyc - t_acc) inside {[NORESP - 1 : NORESP + 2]}, 1'b1);
		// A repeated identifier is refused and starts nothing.
		send(3'h5, 1'b1, 1'b0, 1'b0);
		repeat (3) @(negedge CLK);
		check(PRL_CARRIER_MODE, 1'b0);
		// Random plain messages, every third one a repeat.
		for (i = 0; i < 12; i++) begin
			seed = xs(seed);
			send((i % 3 == 2) ? last : seed[2:0], 1'b0, 1'b0, 1'b0);
		end
		check({NORESP_TIMEOUT, PRL_CARRIER_MODE}, 2'h0);
		// A manager request waits behind a received message.
		send(last + 3'h1, 1'b0, 1'b1, 1'b0);
		check(DPM_ACK, 1'b0);
		for (k = 0; k < 4 && DPM_ACK !== 1'b1; k++) @(negedge CLK);
		check(DPM_ACK, 1'b1);
		DPM_REQ = 1'b0;
		// A discard together with an arrival: the arrival is handled, then the retry.
		send(last + 3'h1, 1'b0, 1'b0, 1'b1);
		check(RETRY_REQ, 1'b0);
		for (k = 0; k < 4 && RETRY_REQ !== 1'b1; k++) @(negedge CLK);
		check(RETRY_REQ, 1'b1);
		// Hard reset on the first carrier cycle with a prompt acknowledge.
		ack_dly = 4'h0;
		// Let the partner finish a slow acknowledge so it sees the next one.
		repeat (6) @(negedge CLK);
		send(last + 3'h1, 1'b1, 1'b0, 1'b0);
		for (k = 0; k < 20 && PRL_PATTERN_EN !== 1'b1; k++) @(negedge CLK);
		HARD_RESET = 1'b1;
		@(negedge CLK);
		HARD_RESET = 1'b0;
		check({PRL_CARRIER_MODE, PHY_CARRIER_MODE, PRL_PATTERN_EN, PHY_PATTERN_VALID}, 4'h1);
		// The stream valid is re-registered, so it drops one cycle after the mode flags.
		@(negedge CLK);
		check(PHY_PATTERN_VALID, 1'b0);
		// The stored identifier is forgotten, so the same one is taken again.
		have = 1'b0;
		f0 = n_ok;
		send(last, 1'b1, 1'b0, 1'b0);
		repeat (CONT + 12) @(negedge CLK);
		check(PHY_CARRIER_MODE, 1'b0);
		check(n_ok - f0, 1);
		check(exp_q.size(), 0);
		print_verdict();
	end
endmodule
